/* apf_pkg.sv */
// constants and types for the amplifier protection and fault controller
// Notes on behaviour
// [RL1] both status outputs are active low open drain, for a system controller
// [RL2] any fault that shuts the output stage pulls shutdown alert low
// [RL3] thermal warning pulls its output low above warning level, fault or not
// [RL4] while reset is low the shutdown alert is released high; code keeps it low while the short check runs
// [RL5] a shutdown fault makes affected outputs hi-z at once and asserts alert
// [RL6] faults other than overload and thermal shutdown clear themselves
// [RL7] bootstrap undervoltage turns off only its half bridge, no latch, no alert
// [RL8] bridged: A/B pair and C/D pair shut together; parallel: all four
// [RL9] overcurrent on every switch gives cycle limiting or latched shutdown
// [RL10] cycle limiting flips the half bridge until the next pwm frame
// [RL11] overload counter up per event, down per clean cycle; max latches hi-z
// [RL12] latched mode shuts the output on the first overcurrent event
// [RL13] trip select: four limiting, four latched levels; others give minimum
// [RL14] bridged dc unbalance counts overload up to max then shuts channel; not counted with latched trip codes 4..7
// [RL15] output short check runs only at startup after supply application
// [RL16] a found short holds all half bridges hi-z until removed, then goes on
// [RL17] short check tests ground first then supply, bounded duration
// [RL18] during short check alert low, reset ignored; later reset never reruns it
// [RL19] short check runs in bridged and parallel modes, skipped single ended
// [RL20] over shutdown temperature: all hi-z, alert low, latched until reset
// [RL21] logic or gate supply undervoltage: all hi-z, alert low, self clearing
// [RL22] power on clear resets overload latch and counters before operation
// [RL23] a rising edge of reset restarts after a latched overload fault
// [RL24] controller keeps alert low at least 4 ms before releasing reset
// [RL25] output mode and trip select are sampled while reset is low
package apf_pkg;

  // ***************************************************************
  // output configuration and trip select
  // ***************************************************************
  localparam logic [1:0] APF_MODE_BRIDGED = 2'h0;
  localparam logic [1:0] APF_MODE_PARALLEL = 2'h1;
  localparam logic [1:0] APF_MODE_SINGLE = 2'h2;
  // trip select codes 0..3 limiting, 4..7 latched; step index is low bits
  localparam logic [3:0] APF_TRIP_LATCH_LO = 4'h4;
  localparam logic [3:0] APF_TRIP_LAST = 4'h7;
  localparam logic [1:0] APF_STEP_MIN = 2'h3;

  // ***************************************************************
  // overload counter
  // ***************************************************************
  localparam int APF_OLC_W = 6;
  localparam logic [APF_OLC_W-1:0] APF_OLC_MAX = 6'h3F;
  localparam logic [APF_OLC_W-1:0] APF_OLC_ONE = 6'h01;
  localparam logic [APF_OLC_W-1:0] APF_OLC_ZERO = 6'h00;

  // ***************************************************************
  // timing at 25 MHz
  // ***************************************************************
  localparam int APF_CLK_HZ = 25000000;
  localparam int APF_STEP_US = 1000;
  localparam int APF_STEP_CYC = APF_CLK_HZ / 1000000 * APF_STEP_US;
  localparam int APF_TMR_W = 16;

  typedef enum logic [2:0] {
    APF_SC_IDLE = 3'b000,
    APF_SC_GND = 3'b001,
    APF_SC_SUP = 3'b010,
    APF_SC_DONE = 3'b011
  } apf_sc_e;

endpackage

/* apf_half_bridge.sv */
// per half bridge overcurrent limiting and overload counting
`timescale 1ns/1ns
`default_nettype none
module apf_half_bridge
  import apf_pkg::*;
(
  // clock and clear
  input wire logic mclk,
  input wire logic clr,
  // frame and events
  input wire logic frame_start,
  input wire logic oc_event,
  input wire logic dc_event,
  input wire logic latched_mode,
  input wire logic dc_enable,
  // results
  output logic flip,
  output logic ovl_latched
);

  logic [APF_OLC_W-1:0] cnt_reg;
  logic hit_reg;

  // flip state until next frame; latched mode does not flip
  always_ff @(posedge mclk) begin
    if (clr || frame_start) begin
      flip <= 1'b0; // see [RL10]
    end else if (oc_event && !latched_mode) begin
      flip <= 1'b1; // see [RL10]
    end
  end

  // remembers an event in the current frame
  always_ff @(posedge mclk) begin
    if (clr || frame_start) begin
      hit_reg <= 1'b0;
    end else if (oc_event || (dc_event && dc_enable)) begin
      hit_reg <= 1'b1;
    end
  end

  // counter steps up on each cycle an event is present outside latched mode, down once per clean frame
  always_ff @(posedge mclk) begin
    if (clr) begin
      cnt_reg <= APF_OLC_ZERO; // see [RL22]
    end else if ((oc_event || (dc_event && dc_enable)) && !latched_mode &&
                 cnt_reg != APF_OLC_MAX) begin
      cnt_reg <= cnt_reg + APF_OLC_ONE; // see [RL11] see [RL14]
    end else if (frame_start && !hit_reg && cnt_reg != APF_OLC_ZERO) begin
      cnt_reg <= cnt_reg - APF_OLC_ONE; // see [RL11]
    end
  end

  // overload latch held until reset cycle
  always_ff @(posedge mclk) begin
    if (clr) begin
      ovl_latched <= 1'b0; // see [RL22] see [RL23]
    end else if (oc_event && latched_mode) begin
      ovl_latched <= 1'b1; // see [RL12]
    end else if (cnt_reg == APF_OLC_MAX) begin
      ovl_latched <= 1'b1; // see [RL11] see [RL14]
    end
  end

endmodule
`default_nettype wire

/* apf_top.sv */
// protection and fault control for a four half bridge amplifier stage
`timescale 1ns/1ns
`default_nettype none
module apf_top
  import apf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // controller reset pin, active low
  input wire logic dev_reset_n,
  // static configuration
  input wire logic [1:0] output_mode,
  input wire logic [3:0] current_trip_select,
  // pwm frame reference
  input wire logic frame_start,
  // comparator inputs, one bit per half bridge a..d, dc unbalance one bit per bridged pair
  input wire logic [3:0] oc_hi,
  input wire logic [3:0] oc_lo,
  input wire logic [1:0] dc_unbalance,
  input wire logic [3:0] boot_undervolt,
  // supply and thermal monitors
  input wire logic supply_undervolt,
  input wire logic gate_drive_supply_uv,
  input wire logic thermal_warning,
  input wire logic thermal_shutdown,
  // short check comparators
  input wire logic short_to_gnd,
  input wire logic short_to_supply,
  // shutdown alert, open drain
  output logic fault_n_o,
  output logic fault_n_oe,
  // thermal warning, open drain
  output logic thermal_warn_n_o,
  output logic thermal_warn_n_oe,
  // power stage control
  output logic [3:0] hb_hiz,
  output logic [3:0] hb_flip,
  output logic [3:0] hb_high_off,
  // status
  output logic [1:0] trip_step,
  output logic short_check_busy
);

  // ***************************************************************
  // synchronisers for all pins
  // ***************************************************************
  localparam int SW = 24;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] pins;
  assign pins = {dev_reset_n, output_mode, current_trip_select, frame_start,
                 oc_hi, oc_lo, dc_unbalance, boot_undervolt,
                 supply_undervolt, gate_drive_supply_uv};
  always_ff @(posedge mclk) begin
    s1_reg <= pins;
    s2_reg <= s1_reg;
  end

  logic rst_n_s;
  logic [1:0] mode_s;
  logic [3:0] trip_s;
  logic frame_s;
  logic [3:0] oc_s;
  logic [1:0] dc_s;
  logic [3:0] bst_s;
  logic uv_s;
  assign rst_n_s = s2_reg[23];
  assign mode_s = s2_reg[22:21];
  assign trip_s = s2_reg[20:17];
  assign frame_s = s2_reg[16];
  assign oc_s = s2_reg[15:12] | s2_reg[11:8]; // see [RL9]
  assign dc_s = s2_reg[7:6];
  assign bst_s = s2_reg[5:2];
  assign uv_s = s2_reg[1] | s2_reg[0];

  // thermal and short pins take their own two stages
  logic [3:0] t1_reg;
  logic [3:0] t2_reg;
  always_ff @(posedge mclk) begin
    t1_reg <= {thermal_warning, thermal_shutdown, short_to_gnd,
               short_to_supply};
    t2_reg <= t1_reg;
  end
  logic warn_s;
  logic ote_s;
  logic sgnd_s;
  logic ssup_s;
  assign warn_s = t2_reg[3];
  assign ote_s = t2_reg[2];
  assign sgnd_s = t2_reg[1];
  assign ssup_s = t2_reg[0];
  // bootstrap lines stay per half bridge, apart from the global supply bits
  logic [3:0] bst_only;
  assign bst_only = bst_s;

  // ***************************************************************
  // reset edge and configuration capture
  // ***************************************************************
  logic rst_n_d_reg;
  logic sc_active;
  logic rst_rise;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_n_d_reg <= 1'b0;
    end else begin
      rst_n_d_reg <= rst_n_s;
    end
  end
  // reset pin ignored while short check runs
  assign rst_rise = rst_n_s && !rst_n_d_reg && !sc_active; // see [RL18]

  logic [1:0] mode_reg;
  logic [3:0] trip_reg;
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg <= APF_MODE_BRIDGED;
      trip_reg <= 4'h0;
    end else if (!rst_n_s) begin
      mode_reg <= mode_s; // see [RL25]
      trip_reg <= trip_s; // see [RL25]
    end
  end

  // ***************************************************************
  // trip decode
  // ***************************************************************
  logic latched_mode;
  logic [1:0] step_next;
  always_comb begin
    latched_mode = trip_reg >= APF_TRIP_LATCH_LO;
    step_next = trip_reg[1:0];
    if (trip_reg > APF_TRIP_LAST) begin
      // out of range codes give minimum threshold in limiting mode
      latched_mode = 1'b0;
      step_next = APF_STEP_MIN; // see [RL13]
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      trip_step <= APF_STEP_MIN;
    end else begin
      trip_step <= step_next; // see [RL13]
    end
  end

  // ***************************************************************
  // output short check sequencer, startup only
  // ***************************************************************
  apf_sc_e sc_reg;
  logic [APF_TMR_W-1:0] tmr_reg;
  logic tmr_done;
  assign tmr_done = tmr_reg == APF_TMR_W'(APF_STEP_CYC - 1);
  assign sc_active = (sc_reg == APF_SC_GND) || (sc_reg == APF_SC_SUP);

  // srst stands for supply application; the device reset pin never reruns
  always_ff @(posedge mclk) begin
    if (srst) begin
      sc_reg <= APF_SC_IDLE; // see [RL15]
    end else begin
      case (sc_reg)
        APF_SC_IDLE: begin
          if (mode_s == APF_MODE_SINGLE) begin
            sc_reg <= APF_SC_DONE; // see [RL19]
          end else begin
            sc_reg <= APF_SC_GND;
          end
        end
        APF_SC_GND: begin
          if (tmr_done && !sgnd_s) begin
            sc_reg <= APF_SC_SUP; // see [RL17]
          end
        end
        APF_SC_SUP: begin
          if (sgnd_s) begin
            sc_reg <= APF_SC_GND; // see [RL16]
          end else if (tmr_done && !ssup_s) begin
            sc_reg <= APF_SC_DONE; // see [RL17]
          end
        end
        APF_SC_DONE: begin
          sc_reg <= APF_SC_DONE; // see [RL18]
        end
        default: begin
          sc_reg <= APF_SC_IDLE;
        end
      endcase
    end
  end

  // step timer restarts while a short is seen, holding hi-z
  always_ff @(posedge mclk) begin
    if (srst || !sc_active || tmr_done) begin
      tmr_reg <= '0;
    end else if ((sc_reg == APF_SC_GND && sgnd_s) ||
                 (sc_reg == APF_SC_SUP && ssup_s)) begin
      tmr_reg <= '0; // see [RL16]
    end else begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      short_check_busy <= 1'b0;
    end else begin
      short_check_busy <= sc_active;
    end
  end

  // ***************************************************************
  // per half bridge overcurrent and overload
  // ***************************************************************
  logic clr_ovl;
  logic [3:0] flip_w;
  logic [3:0] ovl_w;
  logic dc_en;
  // power on clear and reset edge clear the overload state
  assign clr_ovl = srst || rst_rise; // see [RL22] see [RL23]
  assign dc_en = mode_reg == APF_MODE_BRIDGED; // see [RL14]

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hb
      apf_half_bridge u_hb (
        .mclk(mclk),
        .clr(clr_ovl),
        .frame_start(frame_s),
        .oc_event(oc_s[g] && sc_reg == APF_SC_DONE),
        .dc_event(dc_s[g/2]),
        .latched_mode(latched_mode),
        .dc_enable(dc_en),
        .flip(flip_w[g]),
        .ovl_latched(ovl_w[g])
      );
    end
  endgenerate

  // ***************************************************************
  // thermal shutdown latch
  // ***************************************************************
  logic ote_reg;
  always_ff @(posedge mclk) begin
    if (srst || !rst_n_s) begin
      ote_reg <= 1'b0; // see [RL20]
    end else if (ote_s) begin
      ote_reg <= 1'b1; // see [RL20]
    end
  end

  // ***************************************************************
  // shutdown scope and outputs
  // ***************************************************************
  logic [3:0] scope;
  logic global_off;
  logic any_fault;
  always_comb begin
    case (mode_reg)
      APF_MODE_PARALLEL: begin
        scope = {4{|ovl_w}}; // see [RL8]
      end
      APF_MODE_BRIDGED: begin
        scope = {{2{|ovl_w[3:2]}}, {2{|ovl_w[1:0]}}}; // see [RL8]
      end
      default: begin
        scope = ovl_w;
      end
    endcase
  end
  // supply undervolt and thermal latch are global and self clear / latch
  assign global_off = uv_s || ote_reg || sc_active ||
                      sc_reg == APF_SC_IDLE; // see [RL21] see [RL6]
  assign any_fault = uv_s || ote_reg || (|ovl_w) || sc_active;

  always_ff @(posedge mclk) begin
    if (srst) begin
      hb_hiz <= 4'hF;
      hb_flip <= 4'h0;
      hb_high_off <= 4'h0;
    end else begin
      hb_hiz <= global_off ? 4'hF : scope; // see [RL5]
      hb_flip <= flip_w; // see [RL10]
      hb_high_off <= bst_only; // see [RL7]
    end
  end

  // alert: reset pin releases it, except while the check runs
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b0;
    end else begin
      fault_n_o <= 1'b0; // see [RL1]
      if (sc_active) begin
        fault_n_oe <= 1'b1; // see [RL18]
      end else if (!rst_n_s) begin
        fault_n_oe <= 1'b0; // see [RL4]
      end else begin
        fault_n_oe <= any_fault; // see [RL2] see [RL5]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      thermal_warn_n_o <= 1'b0;
      thermal_warn_n_oe <= 1'b0;
    end else begin
      thermal_warn_n_o <= 1'b0; // see [RL1]
      thermal_warn_n_oe <= warn_s; // see [RL3]
    end
  end

endmodule
`default_nettype wire

/* apf_top_props.sv */
// concurrent checks on the protection controller top ports
`timescale 1ns/1ns
`default_nettype none
module apf_top_props
  import apf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // inputs watched
  input wire logic dev_reset_n,
  input wire logic [3:0] current_trip_select,
  input wire logic [3:0] boot_undervolt,
  input wire logic supply_undervolt,
  input wire logic thermal_warning,
  input wire logic thermal_shutdown,
  // outputs watched
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic thermal_warn_n_o,
  input wire logic thermal_warn_n_oe,
  input wire logic [3:0] hb_hiz,
  input wire logic [3:0] hb_high_off,
  input wire logic [1:0] trip_step,
  input wire logic short_check_busy
);
  // ****************************************
  // checks, windows cover the sync pipeline
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // codes past the last latched step fall back to the smallest threshold
  function automatic logic [1:0] step_of(input logic [3:0] s);
    return (s > APF_TRIP_LAST) ? APF_STEP_MIN : s[1:0];
  endfunction
  sequence s_therm_trip;
    (thermal_shutdown && dev_reset_n) [*5];
  endsequence
  sequence s_run_on;
    dev_reset_n [*8];
  endsequence
  AST_OD_LOW:
    assert property (!fault_n_o && !thermal_warn_n_o)
    else $error("status pin drives high");
  AST_WARN_ON:
    assert property (thermal_warning [*4] |-> thermal_warn_n_oe)
    else $error("warning not pulled low");
  AST_WARN_OFF:
    assert property (!thermal_warning [*4] |-> !thermal_warn_n_oe)
    else $error("warning held without cause");
  AST_RST_RELEASE:
    assert property ((!dev_reset_n && !short_check_busy) [*5] |-> !fault_n_oe)
    else $error("alert not released in reset");
  AST_UV_HIZ:
    assert property (supply_undervolt [*5] |-> hb_hiz == 4'hF)
    else $error("undervoltage left stage on");
  AST_UV_ALERT:
    assert property ((supply_undervolt && dev_reset_n) [*5] |-> fault_n_oe)
    else $error("undervoltage alert missing");
  AST_THERM_LATCH:
    assert property (s_therm_trip ##1 s_run_on |-> hb_hiz == 4'hF)
    else $error("thermal latch lost");
  AST_BOOT:
    assert property (($stable(boot_undervolt) && dev_reset_n) [*5]
      |-> hb_high_off == boot_undervolt)
    else $error("high side off mismatch");
  AST_TRIP:
    assert property ((!dev_reset_n && $stable(current_trip_select)) [*6]
      |-> trip_step == step_of(current_trip_select))
    else $error("trip step mismatch");
  AST_BUSY_ALERT:
    assert property (short_check_busy [*3] |-> fault_n_oe)
    else $error("alert released during short check");
endmodule
bind apf_top apf_top_props chk (.mclk, .srst, .dev_reset_n,
  .current_trip_select, .boot_undervolt, .supply_undervolt, .thermal_warning,
  .thermal_shutdown, .fault_n_o, .fault_n_oe, .thermal_warn_n_o,
  .thermal_warn_n_oe, .hb_hiz, .hb_high_off, .trip_step, .short_check_busy);
`default_nettype wire

/* apf_mcu_model.sv */
// system controller model: reset pin and pulled-up status lines
`timescale 1ns/1ns
`default_nettype none
module apf_mcu_model #(parameter int MIN_GAP = 40) (
  // clock
  input wire logic mclk,
  // bench request to hold reset
  input wire logic hold_low,
  // device pins
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic thermal_warn_n_o,
  input wire logic thermal_warn_n_oe,
  output logic dev_reset_n,
  output logic fault_line,
  output logic warn_line
);
  // ****************************************
  // pull-ups and reset pacing
  // ****************************************
  int gap = MIN_GAP;
  logic fault_q = 1'b1;
  logic rst_q = 1'b0;
  // pull-ups give a released line its high level
  assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
  assign warn_line = thermal_warn_n_oe ? thermal_warn_n_o : 1'b1;
  assign dev_reset_n = rst_q;
  always @(posedge mclk) begin
    fault_q <= fault_line;
    if (fault_q && !fault_line) gap <= 0;
    else if (gap < MIN_GAP) gap <= gap + 1;
  end
  // release waits out the minimum low time of the alert, scaled down
  always @(posedge mclk) begin
    if (hold_low) rst_q <= 1'b0;
    else if (gap >= MIN_GAP) rst_q <= 1'b1;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the protection controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import apf_pkg::*;
  // ****************************************
  // stimulus, notes and checking
  // ****************************************
  typedef struct {int kind; logic [3:0] exp;} apf_note_s;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hold_low = 1'b1;
  logic [1:0] output_mode = APF_MODE_BRIDGED;
  logic [3:0] current_trip_select = 4'h0;
  logic frame_start = 1'b0;
  logic [3:0] oc_hi = 4'h0, oc_lo = 4'h0, boot_undervolt = 4'h0;
  logic [1:0] dc_unbalance = 2'h0;
  logic supply_undervolt = 1'b0, gate_drive_supply_uv = 1'b0;
  logic thermal_warning = 1'b0, thermal_shutdown = 1'b0;
  logic short_to_gnd = 1'b0, short_to_supply = 1'b0;
  logic dev_reset_n, fault_n_o, fault_n_oe, thermal_warn_n_o;
  logic thermal_warn_n_oe, short_check_busy, fault_line, warn_line;
  logic [3:0] hb_hiz, hb_flip, hb_high_off;
  logic [1:0] trip_step;
  int n_checks = 0, n_mismatch = 0;
  apf_note_s notes[$];
  apf_note_s nt;
  apf_top uut (.mclk, .srst, .dev_reset_n, .output_mode,
    .current_trip_select, .frame_start, .oc_hi, .oc_lo, .dc_unbalance,
    .boot_undervolt, .supply_undervolt, .gate_drive_supply_uv,
    .thermal_warning, .thermal_shutdown, .short_to_gnd, .short_to_supply,
    .fault_n_o, .fault_n_oe, .thermal_warn_n_o, .thermal_warn_n_oe, .hb_hiz,
    .hb_flip, .hb_high_off, .trip_step, .short_check_busy);
  apf_mcu_model #(.MIN_GAP(40)) mcu (.mclk, .hold_low, .fault_n_o,
    .fault_n_oe, .thermal_warn_n_o, .thermal_warn_n_oe, .dev_reset_n,
    .fault_line, .warn_line);
  initial forever #20 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic note(input int k, input logic [3:0] e);
    notes.push_back('{k, e});
  endtask
  task automatic cmp(input string nm, input logic [3:0] e,
    input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frames(input int n, input logic [3:0] hi);
    repeat (n) begin
      oc_hi <= hi;
      tick(1);
      oc_hi <= 4'h0;
      frame_start <= 1'b1;
      tick(1);
      frame_start <= 1'b0;
      tick(6);
    end
  endtask
  // config moves with the reset request; the reset pin falls one clock later
  task automatic dev_reset(input logic [1:0] m, input logic [3:0] s);
    hold_low <= 1'b1;
    output_mode <= m;
    current_trip_select <= s;
    tick(6);
    hold_low <= 1'b0;
    for (int i = 0; i < 200 && !dev_reset_n; i++) tick(1);
    tick(8);
    note(6, 4'h0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // outputs are settled by the falling edge
  always @(negedge mclk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        0: cmp("hb_hiz", nt.exp, hb_hiz);
        1: cmp("hb_flip", nt.exp, hb_flip);
        2: cmp("trip_step", nt.exp, {2'h0, trip_step});
        3: cmp("fault_line", nt.exp, {3'h0, fault_line});
        4: cmp("warn_line", nt.exp, {3'h0, warn_line});
        5: cmp("hb_high_off", nt.exp, hb_high_off);
        default: cmp("busy", nt.exp, {3'h0, short_check_busy});
      endcase
    end
  end
  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'hd7b787bf));
    tick(10);
    srst <= 1'b0;
    for (int i = 0; i < 40 && !short_check_busy; i++) tick(1);
    short_to_gnd <= 1'b1;
    tick(500);
    short_to_gnd <= 1'b0;
    note(6, 4'h1);
    note(3, 4'h0);
    tick(49800);
    note(6, 4'h1);
    for (int i = 0; i < 2000 && short_check_busy; i++) tick(1);
    tick(8);
    note(3, 4'h1);
    for (int s = 0; s < 16; s++) begin
      current_trip_select <= 4'(s);
      tick(8);
      note(2, s > 7 ? 4'h3 : 4'(s % 4));
    end
    dev_reset(APF_MODE_BRIDGED, 4'h0);
    note(0, 4'h0);
    oc_lo <= 4'h2;
    tick(1);
    oc_lo <= 4'h0;
    tick(6);
    note(1, 4'h2);
    frames(1, 4'h0);
    note(1, 4'h0);
    frames(70, 4'h1);
    tick(4);
    note(0, 4'h3);
    note(3, 4'h0);
    dev_reset(APF_MODE_PARALLEL, 4'h4);
    note(0, 4'h0);
    dc_unbalance <= 2'h2;
    frames(70, 4'h0);
    note(0, 4'h0);
    frames(1, 4'h8);
    note(0, 4'hF);
    dev_reset(APF_MODE_BRIDGED, 4'h0);
    frames(70, 4'h0);
    tick(4);
    note(0, 4'hC);
    dc_unbalance <= 2'h0;
    dev_reset(APF_MODE_BRIDGED, 4'h0);
    repeat (6) begin
      thermal_warning <= 1'($urandom);
      tick(8);
      note(4, {3'h0, !thermal_warning});
    end
    thermal_shutdown <= 1'b1;
    tick(10);
    thermal_shutdown <= 1'b0;
    tick(10);
    note(0, 4'hF);
    note(3, 4'h0);
    dev_reset(APF_MODE_BRIDGED, 4'h0);
    note(0, 4'h0);
    for (int k = 0; k < 2; k++) begin
      {supply_undervolt, gate_drive_supply_uv} <= k ? 2'h1 : 2'h2;
      tick(8);
      note(0, 4'hF);
      note(3, 4'h0);
      {supply_undervolt, gate_drive_supply_uv} <= 2'h0;
      tick(8);
      note(0, 4'h0);
      note(3, 4'h1);
    end
    boot_undervolt <= 4'($urandom);
    tick(8);
    note(5, boot_undervolt);
    note(3, 4'h1);
    hold_low <= 1'b1;
    output_mode <= APF_MODE_SINGLE;
    tick(6);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(20);
    note(6, 4'h0);
    note(0, 4'h0);
    tick(2);
    close_out();
  end
endmodule
`default_nettype wire
